// *** dv/mpsc_ctrl_tb_top.sv ***
`timescale 1ns/1ps
module mpsc_ctrl_tb_top;
	import mpsc_pkg::*;
	localparam int unsigned TK = 2;
	logic      mclk;
	logic      resetn;
	logic      pwr_toggle_n;
	logic      pwr_toggle_driven;
	logic      hw_reset_in_n;
	logic      sleep_permit;
	logic      sleep_permit_driven;
	logic      idle_req;
	logic      wake_host_req;
	mpsc_out_t outs;
	int        num_errors;
	int        check_count;
	int        sr_seen;

	mpsc_host_model #(.TICK(TK)) host (.mclk(mclk), .pwr_toggle_n(pwr_toggle_n),
		.pwr_toggle_driven(pwr_toggle_driven), .hw_reset_in_n(hw_reset_in_n),
		.sleep_permit(sleep_permit), .sleep_permit_driven(sleep_permit_driven));

	mpsc_ctrl #(.TICK_CYCLES(TK), .GLITCH(GLITCH_MS)) dut (.mclk(mclk), .resetn(resetn),
		.pwr_toggle_n(pwr_toggle_n), .pwr_toggle_driven(pwr_toggle_driven),
		.hw_reset_in_n(hw_reset_in_n), .sleep_permit(sleep_permit),
		.sleep_permit_driven(sleep_permit_driven), .idle_req(idle_req),
		.wake_host_req(wake_host_req), .outs(outs));

	always #25 mclk = ~mclk;

	task automatic check(string nm, logic exp, logic got);
		check_count++;
		if (got !== exp) begin
			num_errors++;
			$display("mismatch %s expected %b seen %b", nm, exp, got);
		end
	endtask

	task automatic conclude;
		if (num_errors == 0 && check_count > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	task automatic cyc(int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask

	// bounded wait for one output bit, counts startup reports meanwhile
	task automatic wait_bit(string nm, int idx, logic v, int max_ms);
		for (int i = 0; i < max_ms * TK; i++) begin
			if (outs[idx] === v)
				break;
			cyc(1);
			if (outs[0] === 1'b1)
				sr_seen++;
		end
		check(nm, v, outs[idx]);
		if (outs[idx] !== v)
			conclude();
	endtask

	task automatic sc_power_on;
		cyc(1100 * TK);
		check("dp_open_pin", 1'b0, outs.usb_dp_up);
		check("awake_open_pin", 1'b0, outs.awake);
		host.hold_low(0, 700);
		sr_seen = 0;
		cyc(11900 * TK);
		check("dp_early", 1'b0, outs.usb_dp_up);
		wait_bit("dp_attach", 4, 1'b1, 300);
		check("awake_run", 1'b1, outs.awake);
		check("startup_once", 1'b1, sr_seen == 1);
	endtask

	task automatic sc_sleep;
		int n;
		n = 0;
		host.permit(1'b1);
		cyc(4 * TK);
		idle_req = 1'b1;
		cyc(50 * TK);
		check("no_sleep", 1'b1, outs.awake);
		check("serial_on", 1'b1, outs.serial_en);
		host.permit(1'b0);
		wait_bit("asleep", 3, 1'b0, 50);
		check("serial_low", 1'b0, outs.serial_en);
		check("wake_idle", 1'b0, outs.host_wake);
		wake_host_req = 1'b1;
		cyc(1);
		wake_host_req = 1'b0;
		wait_bit("wake_rise", 2, 1'b1, 10);
		while (outs.host_wake === 1'b1 && n < 3000) begin
			cyc(1);
			n++;
		end
		check("wake_len", 1'b1, n >= 999 * TK && n <= 1001 * TK + 1);
		idle_req = 1'b0;
		wait_bit("awake_again", 3, 1'b1, 50);
	endtask

	task automatic sc_refused;
		host.hold_low(0, 2000);
		cyc(20 * TK);
		host.hold_low(0, 700);
		host.hold_low(1, 5);
		cyc(700 * TK);
		check("dp_kept", 1'b1, outs.usb_dp_up);
		check("awake_kept", 1'b1, outs.awake);
	endtask

	task automatic sc_reset;
		host.hold_low(1, 500);
		wait_bit("dp_reset", 4, 1'b0, 100);
		sr_seen = 0;
		wait_bit("dp_reboot", 4, 1'b1, 12300);
		check("startup_again", 1'b1, sr_seen == 1);
	endtask

	task automatic sc_power_off;
		host.hold_low(0, 4000);
		cyc(450 * TK);
		check("dp_held", 1'b1, outs.usb_dp_up);
		wait_bit("dp_detach", 4, 1'b0, 100);
		cyc(1000 * TK);
		check("dp_stays_low", 1'b0, outs.usb_dp_up);
	endtask

	task automatic sc_held_low;
		host.hold_low(0, 1100);
		check("awake_auto", 1'b1, outs.awake);
		host.hold_low(1, 1100);
		cyc(20 * TK);
		check("awake_long_rst", 1'b0, outs.awake);
	endtask

	initial begin
		mclk          = 1'b0;
		resetn        = 1'b0;
		idle_req      = 1'b0;
		wake_host_req = 1'b0;
		num_errors    = 0;
		check_count   = 0;
		sr_seen       = 0;
		repeat (5) @(posedge mclk);
		#1;
		resetn = 1'b1;
		cyc(2);
		sc_power_on();
		sc_sleep();
		sc_refused();
		sc_reset();
		sc_power_off();
		sc_held_low();
		conclude();
	end
endmodule // mpsc_ctrl_tb_top

// *** dv/mpsc_host_model.sv ***
`timescale 1ns/1ps
// host side: drives the control pins of the module
module mpsc_host_model #(
	parameter int unsigned TICK = 2
) (
	input  wire logic mclk,
	output logic      pwr_toggle_n,
	output logic      pwr_toggle_driven,
	output logic      hw_reset_in_n,
	output logic      sleep_permit,
	output logic      sleep_permit_driven
);
	// open pins show the wrong level, only the pull may decide
	initial begin
		pwr_toggle_n        = 1'b0;
		pwr_toggle_driven   = 1'b0;
		hw_reset_in_n       = 1'b1;
		sleep_permit        = 1'b1;
		sleep_permit_driven = 1'b0;
	end
	// low pulse of ms milliseconds, sel 0 toggle, sel 1 reset
	task automatic hold_low(bit sel, int ms);
		if (sel) begin
			hw_reset_in_n = 1'b0;
		end else begin
			pwr_toggle_driven = 1'b1;
			pwr_toggle_n      = 1'b0;
		end
		repeat (ms * TICK) @(posedge mclk);
		#1;
		if (sel) begin
			hw_reset_in_n = 1'b1;
		end else begin
			pwr_toggle_driven = 1'b0;
		end
	endtask
	// high drives the permit pin, low leaves it open
	task automatic permit(bit hi);
		sleep_permit_driven = hi;
		sleep_permit        = 1'b1;
	endtask
endmodule // mpsc_host_model

// *** hw/mpsc_ctrl.sv ***
`timescale 1ns/1ps
// Function
// RULE1: low on toggle after supply starts boot
// RULE2: 0.5 to 1.0 s low turns on
// RULE3: usb d+ rises 12 s after on
// RULE4: 3 to 5 s low turns off
// RULE5: d+ drops 0.5 s after off window
// RULE6: toggle held low starts automatically
// RULE7: reset input low pulse resets module
// RULE8: after reset reboot, then startup report
// RULE9: reset low over 1 s powers off
// RULE10: sleep-permit high blocks sleep
// RULE11: open sleep-permit reads low
// RULE12: host holds permit high for serial
// RULE13: awake output high awake, low asleep
// RULE14: serial lines low during sleep
// RULE15: host wake only when needed
// RULE16: host wake pulse lasts one second
// RULE17: toggle input pulled up internally
// RULE18: pulse meaning follows power state
// RULE19: slow timebase, glitches filtered
module mpsc_ctrl #(
	parameter int unsigned TICK_CYCLES = mpsc_pkg::TICK_CYC,
	parameter int unsigned GLITCH      = mpsc_pkg::GLITCH_MS
) (
	input  wire logic            mclk,
	input  wire logic            resetn,
	input  wire logic            pwr_toggle_n,
	input  wire logic            pwr_toggle_driven,
	input  wire logic            hw_reset_in_n,
	input  wire logic            sleep_permit,
	input  wire logic            sleep_permit_driven,
	input  wire logic            idle_req,
	input  wire logic            wake_host_req,
	output mpsc_pkg::mpsc_out_t  outs
);
	import mpsc_pkg::*;

	mpsc_state_t      st_q;
	logic [31:0]      tdiv_q;
	logic             tick_q;
	logic [MS_W-1:0]  seq_q;
	logic [MS_W-1:0]  wake_q;
	logic             toggle_s;
	logic             rst_s;
	logic             permit_s;
	logic             toggle_raw;
	logic             permit_raw;
	logic [MS_W-1:0]  tog_ms;
	logic [MS_W-1:0]  rst_ms;
	logic             tog_low;
	logic             tog_rel;
	logic             rst_low;
	logic             rst_rel;
	logic             powered_q;
	mpsc_out_t        outs_q;
	logic [31:0]      wake_len_q;

	// undriven toggle reads high, undriven permit reads low
	assign toggle_raw = pwr_toggle_driven ? pwr_toggle_n : 1'b1; // RULE17
	assign permit_raw = sleep_permit_driven ? sleep_permit : 1'b0; // RULE11

	mpsc_sync #(.RST_VAL(1'b1)) u_sync_tog (
		.mclk   (mclk),
		.resetn (resetn),
		.din    (toggle_raw),
		.dout   (toggle_s)
	);
	mpsc_sync #(.RST_VAL(1'b1)) u_sync_rst (
		.mclk   (mclk),
		.resetn (resetn),
		.din    (hw_reset_in_n),
		.dout   (rst_s)
	);
	mpsc_sync #(.RST_VAL(1'b0)) u_sync_perm (
		.mclk   (mclk),
		.resetn (resetn),
		.din    (permit_raw),
		.dout   (permit_s)
	);

	// ms timebase
	always_ff @(posedge mclk) begin
		if (!resetn) begin
			tdiv_q <= '0;
			tick_q <= 1'b0;
		end else if (tdiv_q >= TICK_CYCLES - 1) begin // RULE19
			tdiv_q <= '0;
			tick_q <= 1'b1;
		end else begin
			tdiv_q <= tdiv_q + 32'h1;
			tick_q <= 1'b0;
		end
	end

	mpsc_pulse_meter #(.GLITCH(GLITCH)) u_meter_tog (
		.mclk     (mclk),
		.resetn   (resetn),
		.tick     (tick_q),
		.lvl_n    (toggle_s),
		.low_ms   (tog_ms),
		.is_low   (tog_low),
		.released (tog_rel)
	);
	mpsc_pulse_meter #(.GLITCH(GLITCH)) u_meter_rst (
		.mclk     (mclk),
		.resetn   (resetn),
		.tick     (tick_q),
		.lvl_n    (rst_s),
		.low_ms   (rst_ms),
		.is_low   (rst_low),
		.released (rst_rel)
	);

	// main power sequence
	always_ff @(posedge mclk) begin
		if (!resetn) begin
			st_q      <= MPSC_OFF;
			seq_q     <= '0;
			powered_q <= 1'b0;
		end else begin
			case (st_q)
				MPSC_OFF: begin
					seq_q <= '0;
					// on window pulse, or held low past window
					if (tog_rel && tog_ms >= MS_W'(ON_MIN_MS)
						&& tog_ms <= MS_W'(ON_MAX_MS)) begin // RULE1 RULE2 RULE18
						st_q <= MPSC_BOOT;
					end else if (tog_low && tog_ms > MS_W'(ON_MAX_MS)
						&& !powered_q) begin // RULE6
						st_q      <= MPSC_BOOT;
						powered_q <= 1'b1;
					end
					if (toggle_s) begin
						powered_q <= 1'b0;
					end
				end
				MPSC_BOOT: begin
					if (rst_low && rst_ms > MS_W'(RST_MAX_MS)) begin // RULE9
						st_q  <= MPSC_OFF;
						seq_q <= '0;
					end else if (tick_q) begin
						if (seq_q >= MS_W'(ATTACH_MS - 1)) begin // RULE3
							st_q  <= MPSC_RUN;
							seq_q <= '0;
						end else begin
							seq_q <= seq_q + 1'b1;
						end
					end
				end
				MPSC_RUN, MPSC_SLEEP: begin
					if (rst_low && rst_ms > MS_W'(RST_MAX_MS)) begin // RULE9
						st_q  <= MPSC_DETACH;
						seq_q <= '0;
					end else if (rst_rel) begin // RULE7 RULE8
						st_q  <= MPSC_BOOT;
						seq_q <= '0;
					end else if (tog_rel && tog_ms >= MS_W'(OFF_MIN_MS)
						&& tog_ms <= MS_W'(OFF_MAX_MS)) begin // RULE4 RULE18
						st_q  <= MPSC_DETACH;
						seq_q <= '0;
					end else if (st_q == MPSC_RUN && idle_req && !permit_s) begin // RULE10
						st_q <= MPSC_SLEEP;
					end else if (st_q == MPSC_SLEEP && (!idle_req || permit_s)) begin
						st_q <= MPSC_RUN;
					end
				end
				MPSC_DETACH: begin
					if (tick_q) begin
						if (seq_q >= MS_W'(DETACH_EXTRA_MS - 1)) begin // RULE5
							st_q  <= MPSC_OFF;
							seq_q <= '0;
							powered_q <= !toggle_s;
						end else begin
							seq_q <= seq_q + 1'b1;
						end
					end
				end
				default: begin
					st_q  <= MPSC_OFF;
					seq_q <= '0;
				end
			endcase
		end
	end

	// host wake pulse timer
	always_ff @(posedge mclk) begin
		if (!resetn) begin
			wake_q <= '0;
		end else if (st_q != MPSC_RUN && st_q != MPSC_SLEEP) begin
			wake_q <= '0;
		end else if (wake_q == '0 && wake_host_req) begin // RULE15
			wake_q <= MS_W'(WAKE_PULSE_MS);
		end else if (tick_q && wake_q != '0) begin // RULE16
			wake_q <= wake_q - 1'b1;
		end
	end

	// registered outputs
	always_ff @(posedge mclk) begin
		if (!resetn) begin
			outs_q <= '0;
		end else begin
			outs_q.usb_dp_up      <= (st_q == MPSC_RUN) || (st_q == MPSC_SLEEP)
				|| (st_q == MPSC_DETACH); // RULE3 RULE5
			outs_q.awake          <= (st_q == MPSC_RUN) || (st_q == MPSC_BOOT); // RULE13
			outs_q.host_wake      <= (wake_q != '0); // RULE16
			outs_q.serial_en      <= (st_q == MPSC_RUN) && permit_s; // RULE12 RULE14
			outs_q.startup_report <= (st_q == MPSC_BOOT) && tick_q
				&& (seq_q >= MS_W'(ATTACH_MS - 1)); // RULE8
		end
	end
	assign outs = outs_q;

	// helper: cycles the host wake pulse has stood
	always_ff @(posedge mclk) begin
		if (!resetn) begin
			wake_len_q <= '0;
		end else if (outs_q.host_wake) begin
			wake_len_q <= wake_len_q + 32'h1;
		end else begin
			wake_len_q <= '0;
		end
	end

	sequence s_on_pulse;
		st_q == MPSC_OFF && tog_rel
			&& tog_ms >= MS_W'(ON_MIN_MS) && tog_ms <= MS_W'(ON_MAX_MS);
	endsequence
	sequence s_off_pulse;
		(st_q == MPSC_RUN || st_q == MPSC_SLEEP) && tog_rel
			&& tog_ms >= MS_W'(OFF_MIN_MS) && tog_ms <= MS_W'(OFF_MAX_MS);
	endsequence
	sequence s_rst_long;
		st_q != MPSC_OFF && rst_low && rst_ms > MS_W'(RST_MAX_MS);
	endsequence
	sequence s_boot_done;
		st_q == MPSC_BOOT ##1 st_q == MPSC_RUN;
	endsequence
	sequence s_off_done;
		st_q == MPSC_DETACH ##1 st_q == MPSC_OFF;
	endsequence
	sequence s_wake_load;
		wake_q == '0 && wake_host_req && (st_q == MPSC_RUN || st_q == MPSC_SLEEP);
	endsequence

	a_sleep_blocked: assert property (@(posedge mclk) disable iff (!resetn) // RULE10
		permit_s |=> st_q != MPSC_SLEEP || $past(st_q) == MPSC_SLEEP)
		else $error("sleep entered while permit high");
	a_awake_matches: assert property (@(posedge mclk) disable iff (!resetn) // RULE13
		st_q == MPSC_SLEEP |=> !outs.awake)
		else $error("awake high in sleep");
	a_awake_run: assert property (@(posedge mclk) disable iff (!resetn) // RULE13
		st_q == MPSC_RUN |=> outs.awake)
		else $error("awake low while running");
	a_serial_low: assert property (@(posedge mclk) disable iff (!resetn) // RULE14
		st_q == MPSC_SLEEP |=> !outs.serial_en)
		else $error("serial active in sleep");
	a_serial_on: assert property (@(posedge mclk) disable iff (!resetn) // RULE12
		st_q == MPSC_RUN && permit_s |=> outs.serial_en)
		else $error("serial off while permit high");
	a_wake_idle: assert property (@(posedge mclk) disable iff (!resetn) // RULE16
		(st_q == MPSC_OFF) |=> ##1 !outs.host_wake)
		else $error("host wake while off");
	a_wake_start: assert property (@(posedge mclk) disable iff (!resetn) // RULE15
		$rose(outs.host_wake) |-> $past(wake_host_req, 2))
		else $error("host wake without request");
	a_wake_follows: assert property (@(posedge mclk) disable iff (!resetn) // RULE16
		s_wake_load |=> ##1 outs.host_wake)
		else $error("host wake did not follow request");
	a_wake_len: assert property (@(posedge mclk) disable iff (!resetn) // RULE16
		$fell(outs.host_wake) && ($past(st_q, 2) == MPSC_RUN || $past(st_q, 2) == MPSC_SLEEP)
		|-> wake_len_q >= (WAKE_PULSE_MS - 1) * TICK_CYCLES + 1
		&& wake_len_q <= WAKE_PULSE_MS * TICK_CYCLES)
		else $error("host wake pulse length wrong");
	a_on_accept: assert property (@(posedge mclk) disable iff (!resetn) // RULE2
		s_on_pulse |=> st_q == MPSC_BOOT)
		else $error("on pulse not accepted");
	a_auto_start: assert property (@(posedge mclk) disable iff (!resetn) // RULE6
		st_q == MPSC_OFF && tog_low && tog_ms > MS_W'(ON_MAX_MS) && !powered_q
		|=> st_q == MPSC_BOOT)
		else $error("held toggle did not start");
	a_off_accept: assert property (@(posedge mclk) disable iff (!resetn) // RULE4
		s_off_pulse |=> st_q == MPSC_DETACH || st_q == MPSC_BOOT)
		else $error("off pulse not accepted");
	a_rst_reboot: assert property (@(posedge mclk) disable iff (!resetn) // RULE7
		(st_q == MPSC_RUN || st_q == MPSC_SLEEP) && rst_rel |=> st_q == MPSC_BOOT)
		else $error("reset pulse did not reboot");
	a_rst_long: assert property (@(posedge mclk) disable iff (!resetn) // RULE9
		s_rst_long |=> st_q == MPSC_DETACH || st_q == MPSC_OFF)
		else $error("long reset did not power off");
	a_boot_report: assert property (@(posedge mclk) disable iff (!resetn) // RULE8
		s_boot_done |-> outs.startup_report)
		else $error("no startup report after boot");
	a_boot_dp: assert property (@(posedge mclk) disable iff (!resetn) // RULE3
		s_boot_done |=> outs.usb_dp_up)
		else $error("d+ low after boot");
	a_dp_low_off: assert property (@(posedge mclk) disable iff (!resetn) // RULE3
		st_q == MPSC_BOOT |=> !outs.usb_dp_up)
		else $error("d+ high during boot");
	a_dp_off_det: assert property (@(posedge mclk) disable iff (!resetn) // RULE5
		st_q == MPSC_DETACH |=> outs.usb_dp_up)
		else $error("d+ dropped before detach span ended");
	a_dp_after_off: assert property (@(posedge mclk) disable iff (!resetn) // RULE5
		s_off_done |=> !outs.usb_dp_up)
		else $error("d+ high after detach span");
	a_report_once: assert property (@(posedge mclk) disable iff (!resetn) // RULE8
		outs.startup_report |=> !outs.startup_report)
		else $error("startup report longer than one cycle");
endmodule // mpsc_ctrl

// *** hw/mpsc_pkg.sv ***
package mpsc_pkg;
	// timebase: 20 MHz clock, 1 ms tick
	localparam int unsigned CLK_HZ         = 20_000_000;
	localparam int unsigned TICK_US        = 1000;
	localparam int unsigned TICK_CYC       = (CLK_HZ / 1_000_000) * TICK_US;
	// times in ms
	localparam int unsigned ON_MIN_MS      = 500;
	localparam int unsigned ON_MAX_MS      = 1000;
	localparam int unsigned OFF_MIN_MS     = 3000;
	localparam int unsigned OFF_MAX_MS     = 5000;
	localparam int unsigned ATTACH_MS      = 12000;
	localparam int unsigned DETACH_EXTRA_MS = 500;
	localparam int unsigned RST_MAX_MS     = 1000;
	localparam int unsigned WAKE_PULSE_MS  = 1000;
	localparam int unsigned GLITCH_MS      = 10;
	localparam int unsigned MS_W           = 15;

	typedef enum logic [2:0] {
		MPSC_OFF     = 3'b000,
		MPSC_BOOT    = 3'b001,
		MPSC_RUN     = 3'b011,
		MPSC_DETACH  = 3'b010,
		MPSC_SLEEP   = 3'b111
	} mpsc_state_t;

	typedef struct packed {
		logic usb_dp_up;
		logic awake;
		logic host_wake;
		logic serial_en;
		logic startup_report;
	} mpsc_out_t;
endpackage

// *** hw/mpsc_pulse_meter.sv ***
`timescale 1ns/1ps
// measures low time in ms ticks, deglitched; reports on release
module mpsc_pulse_meter
	import mpsc_pkg::*;
#(
	parameter int unsigned GLITCH = GLITCH_MS
) (
	input  wire logic            mclk,
	input  wire logic            resetn,
	input  wire logic            tick,
	input  wire logic            lvl_n,
	output logic [MS_W-1:0]      low_ms,
	output logic                 is_low,
	output logic                 released
);
	logic [MS_W-1:0] cnt_q;
	logic            lvl_q;

	always_ff @(posedge mclk) begin
		if (!resetn) begin
			lvl_q <= 1'b1;
		end else begin
			lvl_q <= lvl_n;
		end
	end

	always_ff @(posedge mclk) begin
		if (!resetn) begin
			cnt_q <= '0;
		end else if (lvl_n) begin
			cnt_q <= '0;
		end else if (tick && cnt_q != {MS_W{1'b1}}) begin
			cnt_q <= cnt_q + 1'b1;
		end
	end

	assign low_ms   = cnt_q;
	assign is_low   = !lvl_n && (cnt_q >= MS_W'(GLITCH));
	assign released = lvl_n && !lvl_q && (cnt_q >= MS_W'(GLITCH));
endmodule // mpsc_pulse_meter

// *** hw/mpsc_sync.sv ***
`timescale 1ns/1ps
// three-stage synchroniser, change accepted when stages two and three agree
module mpsc_sync #(
	parameter logic RST_VAL = 1'b1
) (
	input  wire logic mclk,
	input  wire logic resetn,
	input  wire logic din,
	output logic      dout
);
	logic [2:0] sh_q;

	always_ff @(posedge mclk) begin
		if (!resetn) begin
			sh_q <= {3{RST_VAL}};
		end else begin
			sh_q <= {sh_q[1:0], din};
		end
	end

	always_ff @(posedge mclk) begin
		if (!resetn) begin
			dout <= RST_VAL;
		end else if (sh_q[1] == sh_q[2]) begin
			dout <= sh_q[2];
		end
	end
endmodule // mpsc_sync
